// File: rtl/tick_timer.sv
// module: system tick timer top with ahb-lite registers and interrupt
//
// Contract
// R1: counter, current value and reload value are all 24 bits wide.
// R2: counter decrements; any write to current value clears it to zero.
// R3: while enabled, current value decrements by one each clock until zero.
// R4: edge after reaching zero loads reload value, then decrementing continues.
// R5: wrap flag sets whenever the counter transitions to zero.
// R6: reading the register holding the wrap flag returns it then clears it.
// R7: current value is not initialised at reset; contents undefined.
// R8: software should clear current value before enabling so counting starts from reload.
// R9: zero reload value keeps current count at zero, stopping ticks.
// R10: enable cleared stops decrementing and holds current value unchanged.
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module tick_timer
    import tick_timer_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq
);

    // ****************************************
    // bus front end
    // ****************************************
    logic wr_pend;
    logic rd_pend;
    logic [ADDR_W-1:0] addr_pend;
    logic hreadyout_q;

    ahb_reg_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .wr_pend(wr_pend),
        .rd_pend(rd_pend),
        .addr_pend(addr_pend)
    );

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // a read holds its data phase one wait cycle, so a write that ends just before it is seen
    wire rd_take = hsel && hready && htrans[1] && !hwrite && (hsize == HSIZE_WORD);
    wire rd_fire = rd_pend && !hreadyout_q;
    wire wr_ctrl = wr_pend && hit(addr_pend, CTRL_OFS);
    wire wr_reload = wr_pend && hit(addr_pend, RELOAD_OFS);
    wire wr_current = wr_pend && hit(addr_pend, CURRENT_OFS);
    wire wr_status = wr_pend && hit(addr_pend, IRQ_STATUS_OFS);
    wire wr_mask = wr_pend && hit(addr_pend, IRQ_MASK_OFS);
    wire rd_ctrl = rd_fire && hit(addr_pend, CTRL_OFS);

    // ****************************************
    // registers
    // ****************************************
    logic enable_q;
    logic [COUNT_W-1:0] reload_q;
    logic wrap_flag_q;
    logic wrap_flag_d;
    logic irq_status_q;
    logic irq_status_d;
    logic irq_mask_q;
    logic [COUNT_W-1:0] count;
    logic wrap;
    logic [31:0] rdata_d;
    logic [31:0] hrdata_q;
    logic irq_q;

    tick_down_counter #(
        .WIDTH(COUNT_W)
    ) u_cnt (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(enable_q),
        .clear(wr_current),
        .reload(reload_q),
        .count(count),
        .wrap(wrap)
    );

    // a wrap in the same cycle as the clearing read survives
    assign wrap_flag_d = wrap | (wrap_flag_q & ~rd_ctrl); // R5 R6
    assign irq_status_d = wrap | (irq_status_q & ~(wr_status & hwdata[IRQ_WRAP_BIT]));

    // read data is registered so it stands when the data phase completes
    assign rdata_d = !rd_fire ? 32'h0000_0000 :
        hit(addr_pend, CTRL_OFS) ? ({31'h0000_0000, enable_q} << CTRL_ENABLE_BIT) |
                                   ({31'h0000_0000, wrap_flag_q} << CTRL_WRAP_FLAG_BIT) :
        hit(addr_pend, RELOAD_OFS) ? {8'h00, reload_q} :
        hit(addr_pend, CURRENT_OFS) ? {8'h00, count} : // R1
        hit(addr_pend, IRQ_STATUS_OFS) ? {31'h0000_0000, irq_status_q} :
        hit(addr_pend, IRQ_MASK_OFS) ? {31'h0000_0000, irq_mask_q} : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_q <= CTRL_ENABLE_RST;
            reload_q <= RELOAD_RST;
            irq_mask_q <= IRQ_MASK_RST;
        end else begin
            if (wr_ctrl) begin
                enable_q <= hwdata[CTRL_ENABLE_BIT]; // R10
            end
            if (wr_reload) begin
                reload_q <= hwdata[COUNT_W-1:0]; // R1
            end
            if (wr_mask) begin
                irq_mask_q <= hwdata[IRQ_WRAP_BIT];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wrap_flag_q <= 1'b0;
            irq_status_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            wrap_flag_q <= wrap_flag_d; // R6
            irq_status_q <= irq_status_d;
            irq_q <= irq_status_d & irq_mask_q;
        end
    end

    // hrdata loads at the end of the wait cycle and stands only for the cycle that completes the data phase, then returns to zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
        end else begin
            hrdata_q <= rdata_d;
            hreadyout_q <= !rd_take;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // writes take no wait state; word reads take exactly one
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign irq = irq_q;

endmodule : tick_timer

// File: rtl/tick_timer_pkg.sv
// package: register map, field layout and reset values of the tick timer
package tick_timer_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int unsigned COUNT_W = 24;
    localparam int unsigned ADDR_W = 8;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] RELOAD_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] CURRENT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h10;

    // ****************************************
    // field positions
    // ****************************************
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_WRAP_FLAG_BIT = 16;
    localparam int unsigned IRQ_WRAP_BIT = 0;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic CTRL_ENABLE_RST = 1'b0;
    localparam logic [COUNT_W-1:0] RELOAD_RST = 24'h00_0000;
    localparam logic IRQ_MASK_RST = 1'b0;

    // ****************************************
    // ahb encodings
    // ****************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ = 2'b11;
    localparam logic [2:0] HSIZE_WORD = 3'b010;

endpackage : tick_timer_pkg

// File: rtl/tick_down_counter.sv
// module: 24-bit wrap-on-zero down counter with reload
`timescale 1ns/1ps
module tick_down_counter
    import tick_timer_pkg::*;
#(
    parameter int unsigned WIDTH = COUNT_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic enable,
    input wire logic clear,
    input wire logic [WIDTH-1:0] reload,
    output logic [WIDTH-1:0] count,
    output logic wrap
);

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic at_zero;
    logic [WIDTH-1:0] count_dec;

    assign at_zero = (count_q == '0);
    assign count_dec = count_q - {{(WIDTH-1){1'b0}}, 1'b1}; // R3
    // reload on the edge after zero; zero reload parks the count at zero
    assign count_d = clear ? '0 : // R2
                     !enable ? count_q : // R10
                     at_zero ? reload : count_dec; // R4 R9
    // flag only when the count steps from one down to zero
    assign wrap = enable && !clear && !at_zero && (count_dec == '0); // R5

    // no reset: the count is undefined until software clears it
    always_ff @(posedge hclk) begin // R7
        count_q <= count_d;
    end

    assign count = count_q; // R1

endmodule : tick_down_counter

// File: rtl/ahb_reg_slave.sv
// module: ahb-lite slave front end, captures address phase; the okay response is driven in tick_timer
`timescale 1ns/1ps
module ahb_reg_slave
    import tick_timer_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    output logic wr_pend,
    output logic rd_pend,
    output logic [ADDR_W-1:0] addr_pend
);

    logic valid_req;
    logic wr_q;
    logic rd_q;
    logic [ADDR_W-1:0] addr_q;

    // only whole words are accepted; other sizes become idle data phases
    assign valid_req = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= '0;
        end else if (hready) begin
            wr_q <= valid_req && hwrite;
            rd_q <= valid_req && !hwrite;
            addr_q <= haddr[ADDR_W-1:0];
        end
    end

    assign wr_pend = wr_q;
    assign rd_pend = rd_q;
    assign addr_pend = addr_q;

endmodule : ahb_reg_slave

// File: tb/tick_timer_chk.sv
// checker: port-level assertions for the tick timer
`timescale 1ns/1ps
module tick_timer_chk
    import tick_timer_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic irq
);
    wire rd_a = hsel & hready & htrans[1] & ~hwrite & (hsize == HSIZE_WORD);
    wire wr_a = hsel & hready & htrans[1] & hwrite & (hsize == HSIZE_WORD);
    wire [7:0] ofs = haddr[7:0];
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // read data is registered: it lands two edges after the address phase
    a_ready_high: assert property (!rd_a |=> hreadyout) else $error("hreadyout low without read");
    a_read_wait: assert property (rd_a |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_rd_slot: assert property (hrdata != '0 |-> $past(rd_a, 2)) else $error("hrdata outside slot");
    a_ctrl_bits: assert property ($past(rd_a, 2) && $past(ofs, 2) == CTRL_OFS
        |-> hrdata[31:17] == '0 && hrdata[15:1] == '0) else $error("ctrl spare bits set");
    a_cur_width: assert property ($past(rd_a, 2) && $past(ofs, 2) == CURRENT_OFS
        |-> hrdata[31:24] == '0) else $error("current wider than count");
    a_sts_width: assert property ($past(rd_a, 2) && $past(ofs, 2) == IRQ_STATUS_OFS
        |-> hrdata[31:1] == '0) else $error("status spare bits set");
    a_unmapped_zero: assert property ($past(rd_a, 2) && $past(ofs, 2) > IRQ_MASK_OFS
        |-> hrdata == '0) else $error("unmapped read not zero");
    a_mask_quiet: assert property (wr_a && ofs == IRQ_MASK_OFS ##1 !hwdata[IRQ_WRAP_BIT]
        |-> ##2 !irq) else $error("irq while masked");
    c_irq: cover property (irq);
    c_flag: cover property ($past(rd_a, 2) && hrdata[CTRL_WRAP_FLAG_BIT]);
    c_cur: cover property (rd_a && ofs == CURRENT_OFS);
endmodule : tick_timer_chk

// File: tb/tb_tick_timer.sv
// testbench: register-level scenarios for the tick timer
`timescale 1ns/1ps
module tb_tick_timer;
    import tick_timer_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b000;
    logic hreadyout, hresp, irq;
    int err_count = 0, cmp_count = 0;
    tick_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
    initial begin
        forever #20 hclk = ~hclk;
    end
    // read data is taken at the edge that ends the data phase; one idle cycle between accesses
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        hsize <= HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, '0);
        chk(r, exp);
    endtask : rd_chk
    task automatic t_regs;
        rd_chk(CTRL_OFS, 32'h0000_0000);
        rd_chk(RELOAD_OFS, 32'h0000_0000);
        rd_chk(IRQ_MASK_OFS, 32'h0000_0000);
        rd_chk(IRQ_STATUS_OFS, 32'h0000_0000);
        rd_chk(8'h14, 32'h0000_0000);
        xfer(1'b1, RELOAD_OFS, 32'hffff_ffff);
        rd_chk(RELOAD_OFS, 32'h00ff_ffff);
        $display("test regs done");
    endtask : t_regs
    // enable spans 13 edges: one reload from zero, then twelve decrements
    task automatic t_count;
        xfer(1'b1, RELOAD_OFS, 32'h0000_0100);
        xfer(1'b1, CURRENT_OFS, 32'hffff_ffff);
        rd_chk(CURRENT_OFS, 32'h0000_0000);
        xfer(1'b1, CTRL_OFS, 32'h0000_0001);
        repeat (10) @(posedge hclk);
        xfer(1'b1, CTRL_OFS, 32'h0000_0000);
        rd_chk(CURRENT_OFS, 32'h0000_00f4);
        rd_chk(CURRENT_OFS, 32'h0000_00f4);
        $display("test count done");
    endtask : t_count
    task automatic t_wrap;
        xfer(1'b1, RELOAD_OFS, 32'h0000_0003);
        xfer(1'b1, CURRENT_OFS, 32'h0000_0000);
        xfer(1'b1, CTRL_OFS, 32'h0000_0001);
        repeat (20) @(posedge hclk);
        xfer(1'b1, CTRL_OFS, 32'h0000_0000);
        rd_chk(CTRL_OFS, 32'h0001_0000);
        rd_chk(CTRL_OFS, 32'h0000_0000);
        rd_chk(IRQ_STATUS_OFS, 32'h0000_0001);
        xfer(1'b1, IRQ_MASK_OFS, 32'h0000_0001);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h0000_0001);
        xfer(1'b1, IRQ_MASK_OFS, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h0000_0000);
        xfer(1'b1, IRQ_MASK_OFS, 32'h0000_0001);
        xfer(1'b1, IRQ_STATUS_OFS, 32'h0000_0001);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h0000_0000);
        rd_chk(IRQ_STATUS_OFS, 32'h0000_0000);
        $display("test wrap done");
    endtask : t_wrap
    task automatic t_zero;
        xfer(1'b1, RELOAD_OFS, 32'h0000_0000);
        xfer(1'b1, CURRENT_OFS, 32'h0000_0000);
        xfer(1'b1, CTRL_OFS, 32'h0000_0001);
        repeat (20) @(posedge hclk);
        rd_chk(CURRENT_OFS, 32'h0000_0000);
        rd_chk(CTRL_OFS, 32'h0000_0001);
        xfer(1'b1, CTRL_OFS, 32'h0000_0000);
        $display("test zero done");
    endtask : t_zero
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_count();
        t_wrap();
        t_zero();
        end_sim();
    end
    // the tests need well under 300 cycles
    initial begin
        #100us;
        err_count++;
        end_sim();
    end
endmodule : tb_tick_timer
bind tick_timer tick_timer_chk chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
